// >>> inc/scr_pkg.sv
// Constants, register layouts and state types for the sync character receiver
package scr_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] ADDR_COMMAND   = 4'h0;
	localparam logic [3:0] ADDR_PIN_FUNC  = 4'h1;
	localparam logic [3:0] ADDR_RX_CTL    = 4'h3;
	localparam logic [3:0] ADDR_MODE      = 4'h4;
	localparam logic [3:0] ADDR_TX_CTL    = 4'h5;
	localparam logic [3:0] ADDR_SYNC_LOW  = 4'h6;
	localparam logic [3:0] ADDR_SYNC_HIGH = 4'h7;
	localparam logic [3:0] ADDR_RX_DATA   = 4'h8;
	localparam logic [3:0] ADDR_LINE_CTL  = 4'ha;
	localparam logic [3:0] ADDR_LINE_STAT = 4'hc;
	localparam logic [3:0] ADDR_RX_ERR    = 4'hd;

	localparam logic [7:0] RESET_BYTE = 8'h00;

	// Command field: reset receive checker
	localparam logic [1:0] CMD_RESET_RX_CRC = 2'h1;

	// ****************************************
	// Field layouts, most significant bit first
	// ****************************************
	typedef struct packed {
		logic [1:0] bits_per_char;
		logic       auto_enable;
		logic       enter_hunt;
		logic       crc_enable;
		logic       reserved;
		logic       load_inhibit;
		logic       rx_enable;
	} scr_rx_ctl_t;

	typedef struct packed {
		logic       terminal_ready;
		logic [1:0] bits_per_char;
		logic       send_break;
		logic       tx_enable;
		logic       poly_crc16;
		logic       send_request;
		logic       tx_crc_enable;
	} scr_tx_ctl_t;

	typedef struct packed {
		logic       crc_preset_ones;
		logic [1:0] encoding;
		logic       go_active_poll;
		logic       idle_mark;
		logic       reserved;
		logic       loop_mode;
		logic       sync_short;
	} scr_line_ctl_t;

	typedef struct packed {
		logic [1:0] clock_mode;
		logic       sync_ext;
		logic       sync_long;
		logic [1:0] stop_bits;
		logic       parity_even;
		logic       parity_enable;
	} scr_mode_t;

	typedef struct packed {
		logic [1:0] command;
		logic [5:0] unused;
	} scr_cmd_t;

	// Register port
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} scr_bus_req_t;

	// Character length codes and lengths
	localparam logic [1:0] BPC_5 = 2'h0;
	localparam logic [1:0] BPC_7 = 2'h1;
	localparam logic [1:0] BPC_6 = 2'h2;
	localparam logic [1:0] BPC_8 = 2'h3;
	localparam logic [4:0] LEN_5  = 5'd5;
	localparam logic [4:0] LEN_6  = 5'd6;
	localparam logic [4:0] LEN_7  = 5'd7;
	localparam logic [4:0] LEN_8  = 5'd8;
	localparam logic [4:0] LEN_12 = 5'd12;
	localparam logic [4:0] LEN_16 = 5'd16;

	// Reflected polynomials, data shifted least significant bit first
	localparam logic [15:0] POLY_CRC16 = 16'ha001;
	localparam logic [15:0] POLY_CCITT = 16'h8408;
	localparam logic [15:0] CRC_ONES   = 16'hffff;
	localparam logic [15:0] CRC_ZEROS  = 16'h0000;

	// Status bit positions
	localparam int STAT_RX_AVAIL = 0;
	localparam int STAT_TX_SEND  = 2;
	localparam int STAT_CARRIER  = 3;
	localparam int STAT_HUNT     = 4;
	localparam int ERR_OVERRUN   = 5;
	localparam int ERR_CRC       = 6;

	typedef enum logic [1:0] {
		RX_OFF  = 2'b00,
		RX_HUNT = 2'b01,
		RX_DATA = 2'b11
	} scr_rx_state_t;

	typedef enum logic [1:0] {
		TX_OFF   = 2'b00,
		TX_ARMED = 2'b01,
		TX_DELAY = 2'b11,
		TX_SEND  = 2'b10
	} scr_tx_state_t;

endpackage

// >>> logic/scr_sync_rx.sv
// Sync character receiver with delayed receive checker and transmit alignment
`timescale 1ns/1ps

module scr_sync_rx
	import scr_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       rx_clk_pin,
	input  wire logic       rx_data_pin,
	input  wire logic       tx_clk_pin,
	input  wire logic       carrier_detect_pin_n,
	output logic            tx_data_pin,
	output logic            terminal_ready_or_request_pin_n,
	output logic            send_request_pin_n
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [3:0] pin_meta_q;
	logic [3:0] pin_sync_q;
	logic       rx_clk_prev_q;
	logic       tx_clk_prev_q;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pin_meta_q    <= 4'h0;
			pin_sync_q    <= 4'h0;
			rx_clk_prev_q <= 1'b0;
			tx_clk_prev_q <= 1'b0;
		end else begin
			pin_meta_q    <= {carrier_detect_pin_n, tx_clk_pin, rx_data_pin, rx_clk_pin};
			pin_sync_q    <= pin_meta_q;
			rx_clk_prev_q <= pin_sync_q[0];
			tx_clk_prev_q <= pin_sync_q[2];
		end
	end

	logic rx_tick;
	logic tx_tick;
	logic rx_bit;
	logic carrier_high;
	assign rx_tick      = pin_sync_q[0] & ~rx_clk_prev_q;
	assign tx_tick      = ~pin_sync_q[2] & tx_clk_prev_q;
	assign rx_bit       = pin_sync_q[1];
	assign carrier_high = pin_sync_q[3];

	// ****************************************
	// Register file
	// ****************************************
	scr_bus_req_t  req;
	scr_rx_ctl_t   rx_ctl_wr;
	scr_rx_ctl_t   rx_ctl_q;
	scr_tx_ctl_t   tx_ctl_q;
	scr_line_ctl_t line_ctl_q;
	scr_mode_t     mode_q;
	scr_cmd_t      cmd;
	logic [7:0]    sync_low_q;
	logic [7:0]    sync_high_q;
	logic          req_function_q;

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
	assign cmd = scr_cmd_t'(req.wdata);
	assign rx_ctl_wr = scr_rx_ctl_t'(req.wdata);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_ctl_q       <= scr_rx_ctl_t'(RESET_BYTE);
			tx_ctl_q       <= scr_tx_ctl_t'(RESET_BYTE);
			line_ctl_q     <= scr_line_ctl_t'(RESET_BYTE);
			mode_q         <= scr_mode_t'(RESET_BYTE);
			sync_low_q     <= RESET_BYTE;
			sync_high_q    <= RESET_BYTE;
			req_function_q <= 1'b0;
		end else if (req.wr) begin
			unique case (req.addr)
				ADDR_RX_CTL:    rx_ctl_q       <= scr_rx_ctl_t'(req.wdata);
				ADDR_TX_CTL:    tx_ctl_q       <= scr_tx_ctl_t'(req.wdata);
				ADDR_LINE_CTL:  line_ctl_q     <= scr_line_ctl_t'(req.wdata);
				ADDR_MODE:      mode_q         <= scr_mode_t'(req.wdata);
				ADDR_SYNC_LOW:  sync_low_q     <= req.wdata;
				ADDR_SYNC_HIGH: sync_high_q    <= req.wdata;
				ADDR_PIN_FUNC:  req_function_q <= req.wdata[0];
				default: ;
			endcase
		end
	end

	// ****************************************
	// Lengths and sync pattern
	// ****************************************
	function automatic logic [4:0] char_len(input logic [1:0] code);
		unique case (code)
			BPC_5: char_len = LEN_5;
			BPC_7: char_len = LEN_7;
			BPC_6: char_len = LEN_6;
			BPC_8: char_len = LEN_8;
		endcase
	endfunction

	logic [4:0]  rx_len;
	logic [4:0]  tx_len;
	logic [4:0]  sync_len;
	logic [15:0] sync_pat;
	logic        align_ok;
	logic        hunt_cmd;

	assign rx_len = char_len(rx_ctl_q.bits_per_char);
	assign tx_len = char_len(tx_ctl_q.bits_per_char);

	// External sync code is outside this block; it falls back to the short/long table
	always_comb begin
		unique case ({mode_q.sync_long, line_ctl_q.sync_short})
			2'b01: begin
				sync_len = LEN_6;
				sync_pat = {10'h000, sync_high_q[5:0]};
			end
			2'b00: begin
				sync_len = LEN_8;
				sync_pat = {8'h00, sync_high_q};
			end
			2'b11: begin
				sync_len = LEN_12;
				sync_pat = {4'h0, sync_high_q, sync_low_q[7:4]};
			end
			2'b10: begin
				sync_len = LEN_16;
				sync_pat = {sync_high_q, sync_low_q};
			end
		endcase
	end

	// Alignment restricted to sync and data lengths that tile each other
	assign align_ok = (sync_len == LEN_6) ? (rx_len == LEN_6 && tx_len == LEN_6)
		: (sync_len != LEN_12 && rx_len == LEN_8 && tx_len == LEN_8);

	assign hunt_cmd = req.wr && req.addr == ADDR_RX_CTL
		&& rx_ctl_wr.enter_hunt;

	// ****************************************
	// Receiver
	// ****************************************
	scr_rx_state_t rx_state_q;
	logic [15:0]   rx_sh_q;
	logic [4:0]    rx_cnt_q;
	logic          rx_active;
	logic          rx_active_q;
	logic          sync_hit;
	logic          char_done;
	logic [7:0]    char_val;
	logic          char_load;

	// Auto enable turns the carrier pin into a receiver gate
	assign rx_active = rx_ctl_q.rx_enable
		& ~(rx_ctl_q.auto_enable & carrier_high);

	always_comb begin
		sync_hit = 1'b0;
		unique case (sync_len)
			LEN_6:   sync_hit = rx_sh_q[15:10] == sync_pat[5:0];
			LEN_8:   sync_hit = rx_sh_q[15:8] == sync_pat[7:0];
			LEN_12:  sync_hit = rx_sh_q[15:4] == sync_pat[11:0];
			default: sync_hit = rx_sh_q == sync_pat;
		endcase
	end

	assign char_done = rx_state_q == RX_DATA && rx_tick && rx_cnt_q == rx_len - 5'd1;
	assign char_val  = 8'(({rx_bit, rx_sh_q[15:9]}) >> (5'd8 - rx_len));
	// Inhibited sync characters never reach the queue or the checker
	assign char_load = char_done && !(rx_ctl_q.load_inhibit && char_val == sync_low_q);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_state_q  <= RX_OFF;
			rx_sh_q     <= 16'h0000;
			rx_cnt_q    <= 5'd0;
			rx_active_q <= 1'b0;
		end else begin
			rx_active_q <= rx_active;
			if (!rx_active) begin
				rx_state_q <= RX_OFF;
				rx_cnt_q   <= 5'd0;
			end else if (!rx_active_q || hunt_cmd) begin
				rx_state_q <= RX_HUNT;
				rx_cnt_q   <= 5'd0;
			end else if (rx_tick) begin
				rx_sh_q <= {rx_bit, rx_sh_q[15:1]};
				unique case (rx_state_q)
					RX_HUNT: begin
						if (sync_hit) begin
							// Match is seen one tick late: this tick's bit is data bit one
							rx_state_q <= RX_DATA;
							rx_cnt_q   <= 5'd1;
						end
					end
					RX_DATA: begin
						rx_cnt_q <= char_done ? 5'd0 : rx_cnt_q + 5'd1;
					end
					default: ;
				endcase
			end
		end
	end

	// Hunt test uses the window before this tick's shift
	logic left_hunt;
	assign left_hunt = rx_active && rx_active_q && !hunt_cmd && rx_tick
		&& rx_state_q == RX_HUNT && sync_hit;

	// ****************************************
	// Data queue, delay stage and checker
	// ****************************************
	logic [7:0]  rx_data_q;
	logic        rx_avail_q;
	logic        crc_err_q;
	logic        overrun_q;
	logic [7:0]  last_char_q;
	logic [7:0]  delay_q;
	logic [4:0]  delay_left_q;
	logic        crc_on_q;
	logic [15:0] crc_q;
	logic [15:0] crc_preset;
	logic [15:0] crc_poly;
	logic        data_read;
	logic        crc_reset;

	assign crc_preset = line_ctl_q.crc_preset_ones ? CRC_ONES : CRC_ZEROS;
	assign crc_poly   = tx_ctl_q.poly_crc16 ? POLY_CRC16 : POLY_CCITT;
	assign data_read  = req.rd && req.addr == ADDR_RX_DATA;
	assign crc_reset  = rx_state_q != RX_DATA
		|| (req.wr && req.addr == ADDR_COMMAND && cmd.command == CMD_RESET_RX_CRC);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_data_q  <= RESET_BYTE;
			rx_avail_q <= 1'b0;
			crc_err_q  <= 1'b0;
			overrun_q  <= 1'b0;
		end else if (char_load) begin
			rx_data_q  <= char_val;
			rx_avail_q <= 1'b1;  // New character wins over a read in the same cycle
			crc_err_q  <= crc_q != CRC_ZEROS;
			overrun_q  <= rx_avail_q & ~data_read;
		end else if (data_read) begin
			rx_avail_q <= 1'b0;
		end
	end

	// Checker trails the queue by one character; a character finishes two character times after queuing
	always_ff @(posedge core_clk) begin
		if (rst) begin
			last_char_q  <= RESET_BYTE;
			delay_q      <= RESET_BYTE;
			delay_left_q <= 5'd0;
			crc_on_q     <= 1'b0;
			crc_q        <= CRC_ZEROS;
		end else if (crc_reset) begin
			crc_on_q     <= 1'b0;
			crc_q        <= crc_preset;
			delay_left_q <= 5'd0;
		end else if (char_load) begin
			last_char_q  <= char_val;
			delay_q      <= last_char_q;
			delay_left_q <= rx_len;
			crc_on_q     <= rx_ctl_q.crc_enable;
		end else if (rx_tick && delay_left_q != 5'd0) begin
			delay_q      <= {1'b0, delay_q[7:1]};
			delay_left_q <= delay_left_q - 5'd1;
			if (crc_on_q) begin
				crc_q <= (crc_q >> 1) ^ ((crc_q[0] ^ delay_q[0]) ? crc_poly : CRC_ZEROS);
			end
		end
	end

	// ****************************************
	// Transmitter and alignment
	// ****************************************
	scr_tx_state_t tx_state_q;
	logic [4:0]    align_cnt_q;
	logic [15:0]   tx_sh_q;
	logic [4:0]    tx_left_q;
	logic          idle_level;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_state_q  <= TX_OFF;
			align_cnt_q <= 5'd0;
		end else if (!tx_ctl_q.tx_enable) begin
			tx_state_q <= TX_OFF;
		end else begin
			unique case (tx_state_q)
				TX_OFF: begin
					tx_state_q <= (line_ctl_q.loop_mode && align_ok) ? TX_ARMED : TX_SEND;
				end
				TX_ARMED: begin
					if (left_hunt && line_ctl_q.go_active_poll) begin
						tx_state_q  <= TX_DELAY;
						align_cnt_q <= 5'd1;  // Sync was already complete one tick ago
					end
				end
				TX_DELAY: begin
					if (rx_tick) begin
						align_cnt_q <= align_cnt_q + 5'd1;
						if (align_cnt_q == rx_len - 5'd1) begin
							tx_state_q <= TX_SEND;
						end
					end
				end
				TX_SEND: ;
			endcase
		end
	end

	assign idle_level = ~tx_ctl_q.send_break;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_sh_q     <= 16'h0000;
			tx_left_q   <= 5'd0;
			tx_data_pin <= 1'b1;
		end else if (tx_state_q != TX_SEND) begin
			tx_left_q   <= 5'd0;
			tx_data_pin <= idle_level;
		end else if (tx_ctl_q.send_break || (line_ctl_q.idle_mark && !line_ctl_q.loop_mode)) begin
			tx_data_pin <= idle_level;
		end else if (tx_tick) begin
			if (tx_left_q == 5'd0) begin
				tx_data_pin <= sync_pat[0];
				tx_sh_q     <= sync_pat >> 1;
				tx_left_q   <= sync_len - 5'd1;
			end else begin
				tx_data_pin <= tx_sh_q[0];
				tx_sh_q     <= tx_sh_q >> 1;
				tx_left_q   <= tx_left_q - 5'd1;
			end
		end
	end

	// ****************************************
	// Modem pins and read port
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			terminal_ready_or_request_pin_n <= 1'b1;
			send_request_pin_n              <= 1'b1;
		end else begin
			// Request form: low while the transmitter is enabled but still idle
			terminal_ready_or_request_pin_n <= req_function_q
				? ~(tx_ctl_q.tx_enable && tx_state_q != TX_SEND)
				: ~tx_ctl_q.terminal_ready;
			send_request_pin_n <= ~tx_ctl_q.send_request;
		end
	end

	logic [7:0] line_stat;
	logic [7:0] rx_err_stat;

	always_comb begin
		line_stat                = 8'h00;
		line_stat[STAT_RX_AVAIL] = rx_avail_q;
		line_stat[STAT_TX_SEND]  = tx_state_q == TX_SEND;
		line_stat[STAT_CARRIER]  = ~carrier_high;
		line_stat[STAT_HUNT]     = rx_state_q != RX_DATA;
		rx_err_stat              = 8'h00;
		rx_err_stat[ERR_CRC]     = crc_err_q;
		rx_err_stat[ERR_OVERRUN] = overrun_q;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (req.rd) begin
			unique case (req.addr)
				ADDR_RX_DATA:   reg_rdata <= rx_data_q;
				ADDR_LINE_STAT: reg_rdata <= line_stat;
				ADDR_RX_ERR:    reg_rdata <= rx_err_stat;
				default:        reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule

// >>> sim/scr_remote_station.sv
// Remote synchronous station on the serial side
`timescale 1ns/1ps

module scr_remote_station (
	input  wire logic run,
	output logic      rx_clk,
	output logic      rx_data,
	output logic      tx_clk
);
	initial begin
		rx_clk = 1'b0;
		rx_data = 1'b1;
		tx_clk = 1'b0;
		#7;
		// Same rate as receive clock, still while off line
		forever #200 tx_clk = run ? ~tx_clk : 1'b0;
	end

	// Bits go out least significant first; clock only runs inside a frame
	task automatic send(input logic [39:0] frame, input int n);
		#13;
		for (int i = 0; i < 8 * n; i++) begin
			rx_data = frame[i];
			#200 rx_clk = 1'b1;
			#200 rx_clk = 1'b0;
		end
		// Released line holds no stale bit
		rx_data = ~frame[8 * n - 1];
	endtask
endmodule

// >>> sim/scr_sync_rx_monitor.sv
// Port-level checker for the sync character receiver
`timescale 1ns/1ps

module scr_sync_rx_monitor
	import scr_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       rx_clk_pin,
	input wire logic       rx_data_pin,
	input wire logic       tx_clk_pin,
	input wire logic       carrier_detect_pin_n,
	input wire logic       tx_data_pin,
	input wire logic       terminal_ready_or_request_pin_n,
	input wire logic       send_request_pin_n
);
	// ********
	// Shadow of written controls
	// ********
	scr_tx_ctl_t tx_q;
	logic        func_q;
	logic        rxen_q;
	logic [7:0]  quiet_q;
	logic [2:0]  hunt_q;
	logic        car_q;
	logic [2:0]  cst_q;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_q   <= 8'h00;
			func_q <= 1'b0;
			rxen_q <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == ADDR_TX_CTL) begin
				tx_q <= reg_wdata;
			end
			if (reg_addr == ADDR_PIN_FUNC) begin
				func_q <= reg_wdata[0];
			end
			if (reg_addr == ADDR_RX_CTL) begin
				rxen_q <= reg_wdata[0];
			end
		end
	end

	// Pins are registered, so allow settling after a control write
	always_ff @(posedge core_clk) begin
		if (rst || (reg_wr && (reg_addr == ADDR_TX_CTL || reg_addr == ADDR_PIN_FUNC))) begin
			quiet_q <= 8'h00;
		end else if (quiet_q != 8'hff) begin
			quiet_q <= quiet_q + 8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			hunt_q <= 3'h7;
		end else if (reg_wr && reg_addr == ADDR_RX_CTL && reg_wdata[0]
			&& (reg_wdata[4] || !rxen_q)) begin
			hunt_q <= 3'h0;
		end else if (hunt_q != 3'h7) begin
			hunt_q <= hunt_q + 3'h1;
		end
	end

	// Carrier must be steady past the synchroniser before status is judged
	always_ff @(posedge core_clk) begin
		car_q <= carrier_detect_pin_n;
		if (rst || car_q != carrier_detect_pin_n) begin
			cst_q <= 3'h0;
		end else if (cst_q != 3'h7) begin
			cst_q <= cst_q + 3'h1;
		end
	end

	// ********
	// Properties
	// ********
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);

	property p_term_pin;
		!func_q && quiet_q >= 8'h03 |-> terminal_ready_or_request_pin_n == !tx_q.terminal_ready;
	endproperty
	a_term_pin: assert property (p_term_pin)
		else $error("terminal ready pin wrong");

	property p_req_mode;
		func_q && !tx_q.tx_enable && quiet_q >= 8'h03 |-> terminal_ready_or_request_pin_n;
	endproperty
	a_req_mode: assert property (p_req_mode)
		else $error("request pin active with transmitter off");

	property p_send_req;
		quiet_q >= 8'h03 |-> send_request_pin_n == !tx_q.send_request;
	endproperty
	a_send_req: assert property (p_send_req)
		else $error("send request pin wrong");

	property p_idle_ones;
		!tx_q.tx_enable && !tx_q.send_break && quiet_q >= 8'h30 |-> tx_data_pin;
	endproperty
	a_idle_ones: assert property (p_idle_ones)
		else $error("disabled transmitter not sending ones");

	property p_break_zeros;
		!tx_q.tx_enable && tx_q.send_break && quiet_q >= 8'h30 |-> !tx_data_pin;
	endproperty
	a_break_zeros: assert property (p_break_zeros)
		else $error("break not sending zeros");

	property p_carrier;
		reg_rd && reg_addr == ADDR_LINE_STAT && cst_q >= 3'h5
			|=> reg_rdata[STAT_CARRIER] == !$past(carrier_detect_pin_n);
	endproperty
	a_carrier: assert property (p_carrier)
		else $error("carrier status does not follow pin");

	property p_hunt_entry;
		reg_rd && reg_addr == ADDR_LINE_STAT && hunt_q < 3'h3 |=> reg_rdata[STAT_HUNT];
	endproperty
	a_hunt_entry: assert property (p_hunt_entry)
		else $error("receiver not hunting after enable");

	property p_rdata_idle;
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside read answer");

	c_break: cover property (tx_q.send_break && quiet_q >= 8'h30);
	c_char_read: cover property (reg_rd && reg_addr == ADDR_RX_DATA);
	c_crc_err: cover property (reg_rd && reg_addr == ADDR_RX_ERR ##1 reg_rdata[ERR_CRC]);
endmodule

bind scr_sync_rx scr_sync_rx_monitor u_monitor (
	.core_clk(core_clk),
	.rst(rst),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.rx_clk_pin(rx_clk_pin),
	.rx_data_pin(rx_data_pin),
	.tx_clk_pin(tx_clk_pin),
	.carrier_detect_pin_n(carrier_detect_pin_n),
	.tx_data_pin(tx_data_pin),
	.terminal_ready_or_request_pin_n(terminal_ready_or_request_pin_n),
	.send_request_pin_n(send_request_pin_n)
);

// >>> sim/scr_sync_rx_test.sv
// Self-checking bench for the sync character receiver
`timescale 1ns/1ps

module scr_sync_rx_test;
	import scr_pkg::*;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] data;
		logic       car_n;
		logic       term_n;
		logic       sreq_n;
		logic       txd;
	} scr_row_t;
	logic       core_clk;
	logic       rst;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       rx_clk;
	logic       rx_data;
	logic       tx_clk;
	logic       car_n;
	logic       run;
	logic       tx_data;
	logic       term_n;
	logic       sreq_n;
	logic [7:0] v;
	int         mismatches;
	int         compares;
	logic [7:0] exp_err [4] = '{8'h00, 8'h00, 8'h40, 8'h40};
	logic [7:0] exp_dat [4] = '{8'h5a, 8'h00, 8'h00, 8'h00};
	scr_row_t   rows [6] = '{
		'{ADDR_TX_CTL, 8'h80, 1'b0, 1'b0, 1'b1, 1'b1},
		'{ADDR_TX_CTL, 8'h02, 1'b1, 1'b1, 1'b0, 1'b1},
		'{ADDR_TX_CTL, 8'h10, 1'b0, 1'b1, 1'b1, 1'b0},
		'{ADDR_PIN_FUNC, 8'h01, 1'b1, 1'b1, 1'b1, 1'b0},
		'{ADDR_TX_CTL, 8'h80, 1'b0, 1'b1, 1'b1, 1'b1},
		'{ADDR_PIN_FUNC, 8'h00, 1'b1, 1'b0, 1'b1, 1'b1}};

	scr_sync_rx DUT (
		.core_clk(core_clk),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.rx_clk_pin(rx_clk),
		.rx_data_pin(rx_data),
		.tx_clk_pin(tx_clk),
		.carrier_detect_pin_n(car_n),
		.tx_data_pin(tx_data),
		.terminal_ready_or_request_pin_n(term_n),
		.send_request_pin_n(sreq_n)
	);
	scr_remote_station station (.run(run), .rx_clk(rx_clk), .rx_data(rx_data), .tx_clk(tx_clk));

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// ********
	// Bus and compare tasks
	// ********
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk_pin(input string n, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %b seen %b", n, e, g);
		end
	endtask

	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic wait_char();
		v = 8'h00;
		for (int i = 0; i < 300 && v[STAT_RX_AVAIL] !== 1'b1; i++) begin
			rd(ADDR_LINE_STAT, v);
		end
		if (v[STAT_RX_AVAIL] !== 1'b1) begin
			chk_pin("char arrival", 1'b1, v[STAT_RX_AVAIL]);
			conclude();
		end
	endtask

	// Hunt restarts the checker; three zero characters follow the sync
	task automatic hunt_run(input logic [7:0] line, input logic [7:0] err);
		wr(ADDR_LINE_CTL, line);
		wr(ADDR_RX_CTL, 8'hd9);
		rd(ADDR_LINE_STAT, v);
		chk_pin("hunt", 1'b1, v[STAT_HUNT]);
		fork
			station.send({8'h00, 8'h00, 8'h00, 8'h00, 8'h16}, 4);
		join_none
		for (int i = 0; i < 3; i++) begin
			wait_char();
			rd(ADDR_RX_ERR, v);
			if (i == 2) begin
				chk_reg("crc status after hunt", err, v);
			end
			rd(ADDR_RX_DATA, v);
		end
	endtask

	// ********
	// Main sequence
	// ********
	initial begin
		rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		car_n = 1'b0;
		run = 1'b0;
		mismatches = 0;
		compares = 0;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		run <= 1'b1;
		rd(ADDR_RX_ERR, v);
		chk_reg("error status at reset", 8'h00, v);
		chk_pin("tx line at reset", 1'b1, tx_data);
		rd(4'h2, v);
		chk_reg("unmapped read", 8'h00, v);
		foreach (rows[i]) begin
			car_n <= rows[i].car_n;
			wr(rows[i].addr, rows[i].data);
			repeat (64) @(posedge core_clk);
			rd(ADDR_LINE_STAT, v);
			chk_pin("carrier", ~rows[i].car_n, v[STAT_CARRIER]);
			chk_pin("terminal ready", rows[i].term_n, term_n);
			chk_pin("send request", rows[i].sreq_n, sreq_n);
			chk_pin("tx line", rows[i].txd, tx_data);
		end
		// Checker enabled after the first data character is read, before the second arrives
		car_n <= 1'b0;
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_LINE_CTL, 8'h00);
		wr(ADDR_SYNC_LOW, 8'h16);
		wr(ADDR_SYNC_HIGH, 8'h16);
		wr(ADDR_RX_CTL, 8'hd0);
		wr(ADDR_TX_CTL, 8'h00);
		wr(ADDR_RX_CTL, 8'hd1);
		fork
			station.send({8'h00, 8'h00, 8'h00, 8'h5a, 8'h16}, 5);
		join_none
		for (int i = 0; i < 4; i++) begin
			wait_char();
			rd(ADDR_RX_ERR, v);
			chk_reg("crc status", exp_err[i], v);
			rd(ADDR_RX_ERR, v);
			chk_reg("crc status held", exp_err[i], v);
			rd(ADDR_RX_DATA, v);
			chk_reg("rx data", exp_dat[i], v);
			if (i == 0) begin
				wr(ADDR_RX_CTL, 8'hc9);
			end
		end
		hunt_run(8'h00, 8'h00);
		hunt_run(8'h80, 8'h40);
		// Carrier off under auto enable keeps the receiver deaf
		car_n <= 1'b1;
		wr(ADDR_RX_CTL, 8'he1);
		station.send({24'h000000, 8'h33, 8'h16}, 2);
		rd(ADDR_LINE_STAT, v);
		chk_pin("char while carrier off", 1'b0, v[STAT_RX_AVAIL]);
		car_n <= 1'b0;
		wr(ADDR_RX_CTL, 8'hf1);
		station.send({24'h000000, 8'h33, 8'h16}, 2);
		wait_char();
		rd(ADDR_RX_DATA, v);
		chk_reg("char with carrier", 8'h33, v);
		// Loop alignment: transmitter starts one character after the sync
		wr(ADDR_LINE_CTL, 8'h02);
		wr(ADDR_TX_CTL, 8'h68);
		wr(ADDR_LINE_CTL, 8'h12);
		wr(ADDR_PIN_FUNC, 8'h01);
		wr(ADDR_RX_CTL, 8'hd1);
		station.send({32'h00000000, 8'h16}, 1);
		repeat (4) @(posedge core_clk);
		rd(ADDR_LINE_STAT, v);
		chk_pin("tx armed after sync", 1'b0, v[STAT_TX_SEND]);
		chk_pin("request while armed", 1'b0, term_n);
		station.send({32'h00000000, 8'h33}, 1);
		repeat (4) @(posedge core_clk);
		rd(ADDR_LINE_STAT, v);
		chk_pin("tx aligned", 1'b1, v[STAT_TX_SEND]);
		chk_pin("request after align", 1'b1, term_n);
		conclude();
	end
endmodule
